// File: dmcu_channel.sv
/*
  One DMA channel: control register upper and lower fields, status with
  sticky events, interrupt mask, transfer count and the channel sequencer,
  all behind an APB slave.
  Assumes pclk at 10 MHz, an active-low request pin from outside the clock
  domain, and a datapath on pclk that reports errors on xfer_error.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dmcu_channel
  import dmcu_pkg::*;
#(
  parameter int unsigned CNT_W = DMCU_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DMCU_ADDR_W-1:0] paddr,
  input wire logic [DMCU_DATA_W-1:0] pwdata,
  output logic [DMCU_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dreq_n,
  output logic dack_n,
  output logic xfer_strobe,
  input wire logic xfer_error,
  input wire logic [DMCU_DATA_W-1:0] data_in,
  output logic [DMCU_DATA_W-1:0] data_out,
  output logic channel_busy,
  output logic irq
);

  dmcu_state_e state;
  dmcu_state_e next_state;
  logic [DMCU_DATA_W-1:0] ctrl;
  logic [DMCU_DATA_W-1:0] next_ctrl;
  logic [DMCU_EVT_W-1:0] status;
  logic [DMCU_EVT_W-1:0] next_status;
  logic [DMCU_EVT_W-1:0] mask;
  logic [DMCU_EVT_W-1:0] next_mask;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] next_remain;
  logic [DMCU_DATA_W-1:0] next_prdata;
  logic [DMCU_EVT_W-1:0] events;
  logic [DMCU_EVT_W-1:0] irq_gate;
  logic dreq_sync_n;
  logic addr_hit;
  logic bus_wr;
  logic rd_setup;
  logic launch;
  logic req_ok;
  logic done_evt;
  logic fault_evt;

  dmcu_sync #(
    .W(1),
    .RESET_VAL(1'b1)
  ) u_req_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(dreq_n),
    .sync_out(dreq_sync_n)
  );

  dmcu_byte_lane #(
    .BYTES(DMCU_DATA_W / 8)
  ) u_lane (
    .pclk(pclk),
    .presetn(presetn),
    .load(xfer_strobe),
    .big_endian(ctrl[DMCU_BIG_BIT]),
    .data_in(data_in),
    .data_out(data_out)
  );

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign addr_hit = (paddr == DMCU_CTRL_OFF) || (paddr == DMCU_STAT_OFF) ||
                    (paddr == DMCU_MASK_OFF) || (paddr == DMCU_COUNT_OFF);
  assign pslverr = psel && penable && !addr_hit;
  assign bus_wr = psel && penable && pwrite && addr_hit;
  assign rd_setup = psel && !penable && !pwrite;
  // Only a written one arms the channel
  assign launch = bus_wr && (paddr == DMCU_CTRL_OFF) && pwdata[DMCU_LAUNCH_BIT];

  // Internal requests are always pending; the pin is active low, level sensed
  assign req_ok = !ctrl[DMCU_REQ_SRC_BIT] || !dreq_sync_n;
  assign xfer_strobe = (state != DMCU_IDLE) && req_ok && !xfer_error;
  assign dack_n = !(xfer_strobe && ctrl[DMCU_REQ_SRC_BIT]);
  assign done_evt = xfer_strobe && (remain <= CNT_W'(1));
  assign fault_evt = (state != DMCU_IDLE) && xfer_error;
  assign events = {fault_evt, done_evt};
  assign channel_busy = (state != DMCU_IDLE);

  // Enables gate the interrupt, not the sticky status, so polling still works
  assign irq_gate = {ctrl[DMCU_FAULT_EN_BIT], ctrl[DMCU_DONE_EN_BIT]};
  assign irq = |(status & mask & irq_gate);

  always_comb begin
    next_state = state;
    next_remain = remain;
    unique case (state)
      DMCU_IDLE: begin
        if (launch) begin
          next_state = DMCU_READY;
          next_remain = count;
        end
      end
      DMCU_READY, DMCU_BUSY: begin
        if (fault_evt) begin
          next_state = DMCU_IDLE;
        end else if (done_evt) begin
          next_state = DMCU_IDLE;
          next_remain = '0;
        end else if (xfer_strobe) begin
          next_state = DMCU_BUSY;
          next_remain = remain - CNT_W'(1);
        end
      end
      default: begin
        // The spare code is never entered; recover to idle rather than hang
        next_state = DMCU_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DMCU_IDLE;
      remain <= '0;
    end else begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_count = count;
    // Set wins over a clear landing in the same cycle
    next_status = status | events;
    next_prdata = prdata;
    if (bus_wr) begin
      unique case (paddr)
        DMCU_CTRL_OFF: begin
          // Reserved bits store what is written, so writing zeros clears bit 21
          next_ctrl = pwdata & DMCU_CTRL_STORE;
        end
        DMCU_STAT_OFF: begin
          next_status = (status & ~pwdata[DMCU_EVT_W-1:0]) | events;
        end
        DMCU_MASK_OFF: begin
          next_mask = pwdata[DMCU_EVT_W-1:0];
        end
        DMCU_COUNT_OFF: begin
          next_count = pwdata[CNT_W-1:0];
        end
        default: begin
          next_count = count;
        end
      endcase
    end
    if (rd_setup) begin
      next_prdata = '0;
      unique case (paddr)
        DMCU_CTRL_OFF: begin
          next_prdata = ctrl & DMCU_CTRL_STORE;
        end
        DMCU_STAT_OFF: begin
          next_prdata[DMCU_EVT_W-1:0] = status;
          next_prdata[DMCU_STATE_LSB +: 2] = state;
        end
        DMCU_MASK_OFF: begin
          next_prdata[DMCU_EVT_W-1:0] = mask;
        end
        DMCU_COUNT_OFF: begin
          next_prdata[CNT_W-1:0] = count;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= DMCU_CTRL_RESET;
      status <= DMCU_STAT_RESET;
      mask <= DMCU_MASK_RESET;
      count <= CNT_W'(DMCU_COUNT_RESET);
      prdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      count <= next_count;
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    psel && penable && pwrite && (paddr == DMCU_CTRL_OFF);
  endsequence

  sequence s_ctrl_read;
    psel && !penable && !pwrite && (paddr == DMCU_CTRL_OFF) ##1
      psel && penable && !pwrite && (paddr == DMCU_CTRL_OFF);
  endsequence

  sequence s_ext_waiting;
    (state == DMCU_READY) && ctrl[DMCU_REQ_SRC_BIT] && dreq_sync_n && !xfer_error;
  endsequence

  a_launch_arms: assert property (
    (s_ctrl_write and (pwdata[DMCU_LAUNCH_BIT] && state == DMCU_IDLE))
      |=> (state == DMCU_READY) && (remain == $past(count)))
    else $error("Launch did not arm the channel");

  a_zero_launch_idle: assert property (
    (s_ctrl_write and (!pwdata[DMCU_LAUNCH_BIT] && state == DMCU_IDLE))
      |=> state == DMCU_IDLE)
    else $error("Zero launch write changed channel state");

  a_launch_reads_zero: assert property (
    s_ctrl_read |-> !prdata[DMCU_LAUNCH_BIT] && (prdata[23:0] == ctrl[23:0]))
    else $error("Control read returned launch bit or wrong fields");

  a_done_irq_raise: assert property (
    (done_evt && ctrl[DMCU_DONE_EN_BIT] && mask[DMCU_DONE_BIT] && !bus_wr) |=> irq)
    else $error("Completion interrupt missing");

  a_done_irq_quiet: assert property (
    !ctrl[DMCU_DONE_EN_BIT]
      |-> irq == (status[DMCU_FAULT_BIT] && mask[DMCU_FAULT_BIT] && ctrl[DMCU_FAULT_EN_BIT]))
    else $error("Completion interrupt raised while disabled");

  a_fault_irq_raise: assert property (
    (fault_evt && ctrl[DMCU_FAULT_EN_BIT] && mask[DMCU_FAULT_BIT] && !bus_wr)
      |=> irq && state == DMCU_IDLE)
    else $error("Error interrupt missing");

  a_reset_values: assert property (
    $rose(presetn) |-> ctrl == DMCU_CTRL_RESET)
    else $error("Control register reset value wrong");

  a_byte_order: assert property (
    xfer_strobe |=> data_out == ($past(ctrl[DMCU_BIG_BIT]) ? $past(data_in) :
      {$past(data_in[7:0]), $past(data_in[15:8]), $past(data_in[23:16]), $past(data_in[31:24])}))
    else $error("Byte order does not follow endian bit");

  a_ext_request_wait: assert property (
    s_ext_waiting |-> !xfer_strobe ##1 (state == DMCU_READY))
    else $error("External channel moved without request");

  a_int_request_go: assert property (
    ((state != DMCU_IDLE) && !ctrl[DMCU_REQ_SRC_BIT] && !xfer_error) |-> xfer_strobe && dack_n)
    else $error("Internal request channel did not transfer");

  a_ext_ack_low: assert property (
    (xfer_strobe && ctrl[DMCU_REQ_SRC_BIT]) |-> !dack_n && !dreq_sync_n)
    else $error("External transfer without request or acknowledge");

  a_launch_busy_kept: assert property (
    (s_ctrl_write and (state == DMCU_READY && !xfer_strobe && !xfer_error))
      |=> (state == DMCU_READY) && (remain == $past(remain)))
    else $error("Control write disturbed an armed channel");

  a_done_to_idle: assert property (
    done_evt |=> (state == DMCU_IDLE) && status[DMCU_DONE_BIT])
    else $error("Last word did not finish the channel");

  a_fault_ends: assert property (
    fault_evt |-> !xfer_strobe ##1 ((state == DMCU_IDLE) && status[DMCU_FAULT_BIT]))
    else $error("Transfer error did not end the channel");

  a_fault_irq_quiet: assert property (
    (fault_evt && !ctrl[DMCU_FAULT_EN_BIT] && !bus_wr &&
      !(status[DMCU_DONE_BIT] && mask[DMCU_DONE_BIT] && ctrl[DMCU_DONE_EN_BIT])) |=> !irq)
    else $error("Error interrupt raised while disabled");

  a_status_set_wins: assert property (
    (bus_wr && (paddr == DMCU_STAT_OFF) && done_evt) |=> status[DMCU_DONE_BIT])
    else $error("Status clear hid a completion");

endmodule
`default_nettype wire

// File: dmcu_pkg.sv
/*
  Shared constants for the DMA channel control block: register offsets,
  field positions, reset values and the channel state enumeration.
  Assumes an APB register bus with an 8-bit byte address and 32-bit data.
*/
package dmcu_pkg;

  localparam int unsigned DMCU_ADDR_W = 8;
  localparam int unsigned DMCU_DATA_W = 32;

  localparam logic [7:0] DMCU_CTRL_OFF = 8'h00;
  localparam logic [7:0] DMCU_STAT_OFF = 8'h04;
  localparam logic [7:0] DMCU_MASK_OFF = 8'h08;
  localparam logic [7:0] DMCU_COUNT_OFF = 8'h0C;

  localparam int unsigned DMCU_LAUNCH_BIT = 31;
  localparam int unsigned DMCU_DONE_EN_BIT = 23;
  localparam int unsigned DMCU_FAULT_EN_BIT = 22;
  localparam int unsigned DMCU_RSVD_ONE_BIT = 21;
  localparam int unsigned DMCU_BIG_BIT = 17;
  localparam int unsigned DMCU_REQ_SRC_BIT = 14;
  localparam int unsigned DMCU_REQ_POL_BIT = 13;
  localparam int unsigned DMCU_REQ_LEVEL_BIT = 12;

  localparam logic [31:0] DMCU_CTRL_RESET = 32'h00E2_0000;
  // Bits 31..24 never store: launch is a pulse, the rest read as zero
  localparam logic [31:0] DMCU_CTRL_STORE = 32'h00FF_FFFF;

  localparam int unsigned DMCU_DONE_BIT = 0;
  localparam int unsigned DMCU_FAULT_BIT = 1;
  localparam int unsigned DMCU_STATE_LSB = 4;
  localparam int unsigned DMCU_EVT_W = 2;
  localparam logic [1:0] DMCU_STAT_RESET = 2'h0;
  localparam logic [1:0] DMCU_MASK_RESET = 2'h3;
  localparam logic [15:0] DMCU_COUNT_RESET = 16'h0001;
  localparam int unsigned DMCU_CNT_W = 16;
  localparam int unsigned DMCU_SYNC_STAGES = 2;

  typedef enum logic [1:0] {DMCU_IDLE, DMCU_READY, DMCU_BUSY} dmcu_state_e;

endpackage

// File: dmcu_sync.sv
/*
  Two flip-flop synchroniser for levels arriving from pins.
  Assumes the input may change at any time relative to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module dmcu_sync
  import dmcu_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // Stage one feeds stage two only, to contain metastability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// File: dmcu_byte_lane.sv
/*
  Registered data lane that keeps or reverses byte order per word.
  Assumes the datapath is natively big-endian and load is a one-cycle pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module dmcu_byte_lane
  import dmcu_pkg::*;
#(
  parameter int unsigned BYTES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic big_endian,
  input wire logic [8*BYTES-1:0] data_in,
  output logic [8*BYTES-1:0] data_out
);

  logic [8*BYTES-1:0] swapped;
  logic [8*BYTES-1:0] next_data_out;

  for (genvar b = 0; b < BYTES; b++) begin : g_lane
    assign swapped[8*b +: 8] = data_in[8*(BYTES-1-b) +: 8];
  end

  always_comb begin
    next_data_out = data_out;
    if (load) begin
      next_data_out = big_endian ? data_in : swapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= '0;
    end else begin
      data_out <= next_data_out;
    end
  end

endmodule
`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench for the DMA channel control block: register table,
  launch, completion and fault events, interrupt gating, byte order, request source.
  Assumes dmcu_pkg and dmcu_channel are compiled first; no partner model.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top
  import dmcu_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic dreq_n = 1'b1;
  logic xfer_error = 1'b0;
  logic [31:0] data_in = 32'h1122_3344;
  logic [31:0] prdata, data_out;
  logic pready, pslverr, dack_n, xfer_strobe, channel_busy, irq;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int strobes = 0;
  int dacks = 0;
  int s0;
  logic [31:0] rdv;
  logic errv;
  // Table rows: offset, written word, expected read-back
  logic [7:0] row_addr [4] = '{DMCU_CTRL_OFF, DMCU_CTRL_OFF, DMCU_MASK_OFF, DMCU_COUNT_OFF};
  logic [31:0] row_wr [4] = '{32'h7E00_1000, 32'h00C2_5FFF, 32'h0000_0000, 32'h0000_0003};
  logic [31:0] row_exp [4] = '{32'h0000_1000, 32'h00C2_5FFF, 32'h0000_0000, 32'h0000_0003};

  dmcu_channel dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dreq_n(dreq_n), .dack_n(dack_n), .xfer_strobe(xfer_strobe), .xfer_error(xfer_error),
    .data_in(data_in), .data_out(data_out), .channel_busy(channel_busy), .irq(irq)
  );

  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (xfer_strobe === 1'b1) begin
      strobes++;
    end
    if (dack_n === 1'b0) begin
      dacks++;
    end
    // Generous ceiling: the whole sequence needs well under a thousand cycles
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Master never assumes a latency; it waits for pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdv, e)
  endtask

  task automatic settle();
    @(negedge pclk);
  endtask

  // A channel that never returns to idle is caught by the cycle ceiling
  task automatic wait_idle();
    do @(negedge pclk); while (channel_busy !== 1'b0);
  endtask

  function automatic logic [31:0] swap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (row_addr[i]) begin
      apb(1'b1, row_addr[i], row_wr[i]);
      rd_chk(row_addr[i], row_exp[i]);
    end
    // Second reset in mid-run, then the reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(DMCU_CTRL_OFF, DMCU_CTRL_RESET);
    rd_chk(DMCU_MASK_OFF, 32'h0000_0003);
    rd_chk(DMCU_COUNT_OFF, 32'h0000_0001);
    rd_chk(DMCU_STAT_OFF, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK({errv, rdv}, {1'b1, 32'h0000_0000})
    // Internal request, two words, big-endian, completion interrupt enabled
    apb(1'b1, DMCU_COUNT_OFF, 32'h0000_0002);
    s0 = strobes;
    apb(1'b1, DMCU_CTRL_OFF, 32'h80C2_0000);
    wait_idle();
    `CHK(strobes - s0, 2)
    `CHK(data_out, 32'h1122_3344)
    `CHK(irq, 1'b1)
    rd_chk(DMCU_STAT_OFF, 32'h0000_0001);
    rd_chk(DMCU_CTRL_OFF, 32'h00C2_0000);
    apb(1'b1, DMCU_STAT_OFF, 32'h0000_0003);
    settle();
    `CHK(irq, 1'b0)
    // Completion interrupt disabled, little-endian, one word
    apb(1'b1, DMCU_COUNT_OFF, 32'h0000_0001);
    apb(1'b1, DMCU_CTRL_OFF, 32'h8040_0000);
    wait_idle();
    `CHK(data_out, swap(32'h1122_3344))
    `CHK(irq, 1'b0)
    rd_chk(DMCU_STAT_OFF, 32'h0000_0001);
    apb(1'b1, DMCU_STAT_OFF, 32'h0000_0003);
    // Transfer error with the fault interrupt enabled, then the enable cleared
    xfer_error <= 1'b1;
    s0 = strobes;
    apb(1'b1, DMCU_CTRL_OFF, 32'h80C2_0000);
    wait_idle();
    `CHK({irq, strobes - s0}, {1'b1, 32'd0})
    rd_chk(DMCU_STAT_OFF, 32'h0000_0002);
    apb(1'b1, DMCU_CTRL_OFF, 32'h0082_0000);
    settle();
    `CHK(irq, 1'b0)
    apb(1'b1, DMCU_STAT_OFF, 32'h0000_0003);
    xfer_error <= 1'b0;
    // Zero launch while idle does nothing
    apb(1'b1, DMCU_CTRL_OFF, 32'h00C2_5000);
    settle();
    `CHK(channel_busy, 1'b0)
    // External request: armed channel waits for the pin
    s0 = strobes;
    apb(1'b1, DMCU_CTRL_OFF, 32'h80C2_5000);
    repeat (6) @(posedge pclk);
    `CHK({channel_busy, strobes - s0}, {1'b1, 32'd0})
    apb(1'b1, DMCU_CTRL_OFF, 32'h00C2_5000);
    settle();
    `CHK(channel_busy, 1'b1)
    rd_chk(DMCU_STAT_OFF, 32'h0000_0010);
    @(posedge pclk);
    dreq_n <= 1'b0;
    wait_idle();
    @(posedge pclk);
    dreq_n <= 1'b1;
    `CHK(strobes - s0, 1)
    `CHK(dacks, 1)
    rd_chk(DMCU_STAT_OFF, 32'h0000_0001);
    summarize();
  end
endmodule
`default_nettype wire
